// File: lowspeed_rh_map.svh
// Purpose: register offsets, field positions and reset values for the
//          low-speed threshold and first root hub descriptor registers
// Assumes: byte offsets from the controller's base address
// Notes:   definitions only
`ifndef LOWSPEED_RH_MAP_SVH
`define LOWSPEED_RH_MAP_SVH

`define THR_OFFSET          8'h44
`define RHDA_OFFSET         8'h48

`define THR_FIELD_MSB       11
`define THR_RESET           12'h628
`define THR_RSVD_LSB        12

`define PGD_MSB             31
`define PGD_LSB             24
`define DESC_RSVD_MSB       23
`define DESC_RSVD_LSB       13
`define NO_OC_BIT           12
`define OC_MODE_BIT         11
`define COMPOUND_BIT        10
`define ALWAYS_ON_BIT       9
`define SW_MODE_BIT         8
`define PORT_COUNT_MSB      7

`define PGD_RESET           8'hff
`define NO_OC_RESET         1'h0
`define ALWAYS_ON_RESET     1'h0
`define SW_MODE_RESET       1'h1
// protection mode comes out of reset equal to the switching mode
`define OC_MODE_RESET       `SW_MODE_RESET
`define PORT_COUNT_DEFAULT  8'h01
`define PORT_COUNT_MIN      8'h01
`define PORT_COUNT_MAX      8'h0f

`define PGD_UNIT_US         2000
`define RESERVED_ZERO       32'h0000_0000

`endif

// File: lowspeed_rh_pkg.sv
// Purpose: state types for the threshold / descriptor register bank
// Assumes: field layout from lowspeed_rh_map.svh
// Notes:   types only
package lowspeed_rh_pkg;

	typedef struct packed
	{
		logic [11:0] threshold;
		logic [7:0]  power_good_delay;
		logic        no_overcurrent_guard;
		logic        overcurrent_report_mode;
		logic        ports_always_on;
		logic        switching_mode;
		logic [31:0] rdata;
	} regs_state_type;

	typedef struct packed
	{
		logic start;
	} gate_state_type;

endpackage : lowspeed_rh_pkg

// File: lowspeed_commit_gate.sv
// Purpose: decide whether a low-speed transaction may start this frame
// Assumes: request and remaining frame time synchronous to clk
// Notes:   answer is registered, one cycle after the request
`timescale 1ns/1ps
module lowspeed_commit_gate
(
	input  wire logic        clk,              // system clock
	input  wire logic        nrst,             // sync reset, active low
	input  wire logic [13:0] frame_time_left,  // remaining frame time
	input  wire logic [11:0] threshold,        // held threshold value
	input  wire logic        ls_req,           // low-speed start request
	output logic             ls_start          // start granted, high the cycle after each request that fits
);
	lowspeed_rh_pkg::gate_state_type st;
	lowspeed_rh_pkg::gate_state_type next_st;

	always_comb
	begin
		next_st = st;
		// commit only when the whole short packet still fits before frame end
		next_st.start = ls_req && (frame_time_left >= {2'h0, threshold}); // see [RL1] see [RL2]
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign ls_start = st.start;

endmodule : lowspeed_commit_gate

// File: lowspeed_threshold_roothub_desc_a.sv
// Purpose: low-speed threshold register and first root hub descriptor
// Assumes: simple register port, reads answered one cycle later
// Notes:   hardware never alters the threshold; only software writes do
//
// Summary of operation
// [RL1] A low-speed transaction starts only when the remaining frame time is at least the threshold.
// [RL2] The threshold decides commitment to a low-speed packet of up to 8 bytes before frame end.
// [RL3] The threshold register is at 44h and resets to 628h with all other bits zero.
// [RL4] The controller never changes the threshold by itself; it uses the held value.
// [RL5] Software computes the threshold to cover transmission and set-up overhead.
// [RL6] Software writes reserved bits of both registers as zero.
// [RL7] Software waits power-good delay times 2 ms after powering a port before using it.
// [RL8] The descriptor is at 48h and resets to delay ffh, protection mode 1, switching mode 1, one port.
// [RL9] Bit 12 set means no overcurrent protection, else reporting follows the protection-mode bit.
// [RL10] The protection-mode bit resets equal to the switching-mode bit and matters only without bit 12.
// [RL11] The compound-device bit 10 is read-only and always reads zero.
// [RL12] Bit 9 set means ports always powered, clear means switched as bit 8 chooses.
// [RL13] Bit 8 chooses ganged (0) or per-port (1) switching, valid only with bit 9 clear.
// [RL14] The low byte is a read-only port count between one and fifteen.
// [RL15] Reserved bits of both registers read back as zero whatever is written.
`timescale 1ns/1ps
`include "lowspeed_rh_map.svh"
module lowspeed_threshold_roothub_desc_a
#(
	parameter int         AW         = 8,                    // register address width
	parameter logic [7:0] PORT_COUNT = `PORT_COUNT_DEFAULT   // downstream ports, 1..15
)
(
	input  wire logic          clk,                     // system clock, 50 MHz
	input  wire logic          nrst,                    // sync reset, active low
	input  wire logic [AW-1:0] reg_addr,                // register byte offset
	input  wire logic          reg_wr,                  // write strobe, one cycle
	input  wire logic          reg_rd,                  // read strobe, one cycle
	input  wire logic [31:0]   reg_wdata,               // write data
	output logic      [31:0]   reg_rdata,               // read data, next cycle
	input  wire logic [13:0]   frame_time_left,         // remaining frame time
	input  wire logic          ls_req,                  // low-speed start request
	output logic               ls_start,                // low-speed start granted
	output logic      [7:0]    power_good_delay,        // port power-good delay, 2 ms units
	output logic               no_overcurrent_guard,    // no overcurrent protection
	output logic               overcurrent_report_mode, // per-port overcurrent reporting
	output logic               ports_always_on,         // ports not power switched
	output logic               switching_mode           // per-port power switching
);
	lowspeed_rh_pkg::regs_state_type st;
	lowspeed_rh_pkg::regs_state_type next_st;

	logic        hit_thr;
	logic        hit_rhda;
	logic [31:0] thr_view;
	logic [31:0] rhda_view;

	// full-width compare: aliases of the two offsets must not answer
	assign hit_thr  = (reg_addr == AW'(`THR_OFFSET));
	assign hit_rhda = (reg_addr == AW'(`RHDA_OFFSET));

	// reserved bits are not stored at all, so they cannot read back non-zero
	assign thr_view  = {20'h0, st.threshold}; // see [RL15] see [RL3]
	assign rhda_view = {st.power_good_delay, 11'h0, st.no_overcurrent_guard,
		st.overcurrent_report_mode, 1'h0, st.ports_always_on,
		st.switching_mode, PORT_COUNT}; // see [RL11] see [RL14] see [RL15]

	always_comb
	begin
		next_st = st;
		// only a software write touches the threshold; the gate just reads it
		if (reg_wr && hit_thr)
			next_st.threshold = reg_wdata[`THR_FIELD_MSB:0]; // see [RL4]
		if (reg_wr && hit_rhda)
		begin
			next_st.power_good_delay        = reg_wdata[`PGD_MSB:`PGD_LSB];
			next_st.no_overcurrent_guard    = reg_wdata[`NO_OC_BIT];     // see [RL9]
			next_st.overcurrent_report_mode = reg_wdata[`OC_MODE_BIT];   // see [RL10]
			next_st.ports_always_on         = reg_wdata[`ALWAYS_ON_BIT]; // see [RL12]
			next_st.switching_mode          = reg_wdata[`SW_MODE_BIT];   // see [RL13]
		end
		// a read in the same cycle as a write returns the value held before it
		if (reg_rd)
		begin
			if (hit_thr)
				next_st.rdata = thr_view;
			else if (hit_rhda)
				next_st.rdata = rhda_view;
			else
				next_st.rdata = `RESERVED_ZERO;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			st.threshold               <= `THR_RESET;       // see [RL3]
			st.power_good_delay        <= `PGD_RESET;       // see [RL8]
			st.no_overcurrent_guard    <= `NO_OC_RESET;
			st.overcurrent_report_mode <= `OC_MODE_RESET;   // see [RL10]
			st.ports_always_on         <= `ALWAYS_ON_RESET;
			st.switching_mode          <= `SW_MODE_RESET;
			st.rdata                   <= `RESERVED_ZERO;
		end
		else
			st <= next_st;
	end

	lowspeed_commit_gate u_gate
	(
		.clk             (clk),
		.nrst            (nrst),
		.frame_time_left (frame_time_left),
		.threshold       (st.threshold),
		.ls_req          (ls_req),
		.ls_start        (ls_start)
	); // see [RL1]

	assign reg_rdata               = st.rdata;
	assign power_good_delay        = st.power_good_delay;
	assign no_overcurrent_guard    = st.no_overcurrent_guard;
	assign overcurrent_report_mode = st.overcurrent_report_mode;
	assign ports_always_on         = st.ports_always_on;
	assign switching_mode          = st.switching_mode;

	// checks
	chk_commit_grant: assert property (@(posedge clk) disable iff (!nrst) // see [RL1]
		(ls_req && frame_time_left >= {2'h0, st.threshold}) |=> ls_start)
		else $error("low-speed start not granted with enough frame time");

	chk_commit_refuse: assert property (@(posedge clk) disable iff (!nrst) // see [RL1]
		(!ls_req || frame_time_left < {2'h0, st.threshold}) |=> !ls_start)
		else $error("low-speed start granted without enough frame time");

	chk_thr_reset: assert property (@(posedge clk) disable iff (!nrst) // see [RL3]
		$rose(nrst) |-> (st.threshold == `THR_RESET))
		else $error("threshold reset value wrong");

	chk_thr_held: assert property (@(posedge clk) disable iff (!nrst) // see [RL4]
		!(reg_wr && hit_thr) |=> $stable(st.threshold))
		else $error("threshold changed without a write");

	chk_thr_no_hw: assert property (@(posedge clk) disable iff (!nrst) // see [RL4]
		$changed(st.threshold) |-> $past(reg_wr && hit_thr))
		else $error("threshold moved with no software write");

	chk_thr_load: assert property (@(posedge clk) disable iff (!nrst) // see [RL4]
		(reg_wr && hit_thr) |=> (st.threshold == $past(reg_wdata[`THR_FIELD_MSB:0])))
		else $error("threshold not loaded from write");

	chk_thr_write: assert property (@(posedge clk) disable iff (!nrst) // see [RL4]
		(reg_wr && hit_thr) ##1 (reg_rd && hit_thr)
			|=> (reg_rdata == {20'h0, $past(reg_wdata[`THR_FIELD_MSB:0], 2)}))
		else $error("threshold readback differs from written value");

	chk_thr_readback: assert property (@(posedge clk) disable iff (!nrst) // see [RL3]
		(reg_rd && hit_thr) |=> (reg_rdata == {20'h0, $past(st.threshold)}))
		else $error("threshold read data differs from held value");

	// read data stands until the next read strobe
	chk_rdata_held: assert property (@(posedge clk) disable iff (!nrst) // see [RL3]
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	chk_start_reset: assert property (@(posedge clk) disable iff (!nrst) // see [RL1]
		$rose(nrst) |-> (!ls_start && reg_rdata == `RESERVED_ZERO))
		else $error("grant or read data not clear after reset");

	chk_start_asked: assert property (@(posedge clk) disable iff (!nrst) // see [RL2]
		ls_start |-> $past(ls_req))
		else $error("low-speed start granted without a request");

	chk_desc_reset: assert property (@(posedge clk) disable iff (!nrst) // see [RL8]
		$rose(nrst) |-> (power_good_delay == `PGD_RESET && switching_mode && !ports_always_on))
		else $error("descriptor reset value wrong");

	chk_overcurrent_report_mode_follow: assert property (@(posedge clk) disable iff (!nrst) // see [RL10]
		$rose(nrst) |-> (overcurrent_report_mode == switching_mode))
		else $error("protection mode differs from switching mode at reset");

	chk_desc_fixed: assert property (@(posedge clk) disable iff (!nrst) // see [RL11]
		(reg_rd && hit_rhda) |=> (reg_rdata[`COMPOUND_BIT] == 1'h0
			&& reg_rdata[`PORT_COUNT_MSB:0] == PORT_COUNT))
		else $error("compound bit or port count wrong");

	chk_port_range: assert property (@(posedge clk) disable iff (!nrst) // see [RL14]
		(reg_rd && hit_rhda) |=> (reg_rdata[`PORT_COUNT_MSB:0] >= `PORT_COUNT_MIN
			&& reg_rdata[`PORT_COUNT_MSB:0] <= `PORT_COUNT_MAX))
		else $error("port count outside one to fifteen");

	// the address is taken at the strobe edge, so the decode is looked at one edge back
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst) // see [RL15]
		reg_rd |=> ($past(hit_thr) || $past(hit_rhda) || reg_rdata == `RESERVED_ZERO)
			&& (!$past(hit_thr) || reg_rdata[31:`THR_RSVD_LSB] == 20'h0)
			&& (!$past(hit_rhda) || reg_rdata[`DESC_RSVD_MSB:`DESC_RSVD_LSB] == 11'h0))
		else $error("reserved bits read non-zero");

	chk_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst) // see [RL15]
		(reg_rd && !hit_thr && !hit_rhda) |=> (reg_rdata == `RESERVED_ZERO))
		else $error("unmapped offset read non-zero");

	chk_mode_write: assert property (@(posedge clk) disable iff (!nrst) // see [RL9]
		(reg_wr && hit_rhda) |=> (no_overcurrent_guard == $past(reg_wdata[`NO_OC_BIT])
			&& ports_always_on == $past(reg_wdata[`ALWAYS_ON_BIT])))
		else $error("descriptor mode bits not taken from write");

	chk_sw_write: assert property (@(posedge clk) disable iff (!nrst) // see [RL13]
		(reg_wr && hit_rhda) |=> (overcurrent_report_mode == $past(reg_wdata[`OC_MODE_BIT])
			&& switching_mode == $past(reg_wdata[`SW_MODE_BIT])))
		else $error("protection or switching mode not taken from write");

	chk_pgd_write: assert property (@(posedge clk) disable iff (!nrst) // see [RL8]
		(reg_wr && hit_rhda) |=> (power_good_delay == $past(reg_wdata[`PGD_MSB:`PGD_LSB])))
		else $error("power-good delay not taken from write");

	chk_desc_held: assert property (@(posedge clk) disable iff (!nrst) // see [RL8]
		!(reg_wr && hit_rhda) |=> $stable({power_good_delay, no_overcurrent_guard,
			overcurrent_report_mode, ports_always_on, switching_mode}))
		else $error("descriptor fields changed without a write");

	cov_grant:   cover property (@(posedge clk) disable iff (!nrst) ls_req ##1 ls_start);
	cov_refuse:  cover property (@(posedge clk) disable iff (!nrst) ls_req ##1 !ls_start);
	cov_thr_new: cover property (@(posedge clk) disable iff (!nrst) (reg_wr && hit_thr) ##1 ls_req);
	cov_desc_rd: cover property (@(posedge clk) disable iff (!nrst) reg_rd && hit_rhda);
	cov_wr_rd:   cover property (@(posedge clk) disable iff (!nrst) (reg_wr && hit_thr) ##1 (reg_rd && hit_thr));

endmodule : lowspeed_threshold_roothub_desc_a

// File: tb.sv
// Purpose: self-checking bench for the threshold / root hub descriptor bank
// Assumes: strobe register port, read data loaded by the edge that takes the read strobe
// Notes:   inputs move 1 ns after the rising edge; a port count of three proves the parameter reaches the read data
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] ports = 8'h03;
	logic        clk;
	logic        nrst;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [13:0] frame_time_left;
	logic        ls_req;
	logic        ls_start;
	logic [7:0]  power_good_delay;
	logic        no_overcurrent_guard;
	logic        overcurrent_report_mode;
	logic        ports_always_on;
	logic        switching_mode;
	int          n_errors = 0;
	int          checked = 0;

	lowspeed_threshold_roothub_desc_a #(.AW(8), .PORT_COUNT(ports)) u_lowspeed_threshold_roothub_desc_a
	(
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_time_left(frame_time_left),
		.ls_req(ls_req), .ls_start(ls_start), .power_good_delay(power_good_delay),
		.no_overcurrent_guard(no_overcurrent_guard), .overcurrent_report_mode(overcurrent_report_mode),
		.ports_always_on(ports_always_on), .switching_mode(switching_mode)
	);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : reg_write

	// the edge that takes the strobe also loads reg_rdata, so it is looked at 1 ns later
	task automatic reg_read(input logic [7:0] addr, input logic [31:0] exp);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = addr;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check($sformatf("reg_rdata at %h", addr), exp, reg_rdata);
	endtask : reg_read

	// write, then read back at the very next edge; the two strobes are different signals
	task automatic write_read(input logic [7:0] addr, input logic [31:0] data, input logic [31:0] exp);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		check($sformatf("readback at %h", addr), exp, reg_rdata);
	endtask : write_read

	task automatic gate(input logic req, input logic [13:0] ftl, input logic exp);
		@(posedge clk);
		#1 ls_req = req;
		frame_time_left = ftl;
		@(posedge clk);
		#1 check($sformatf("ls_start ftl %h", ftl), {31'h0, exp}, {31'h0, ls_start});
		ls_req = 1'b0;
	endtask : gate

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial
	begin
		#100000;
		n_errors++;
		print_verdict();
	end

	initial
	begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0000_0000;
		frame_time_left = 14'h0000;
		ls_req = 1'b0;
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		reg_read(8'h44, 32'h0000_0628);
		reg_read(8'h48, {8'hff, 16'h0009, ports});
		check("reset outputs", 32'h0000_05ff, {20'h0, no_overcurrent_guard, overcurrent_report_mode,
			ports_always_on, switching_mode, power_good_delay});
		gate(1'b1, 14'h0628, 1'b1);
		gate(1'b1, 14'h0627, 1'b0);
		$display("test reset values done");
		// ones in reserved bits on purpose, to show they never read back
		reg_write(8'h44, 32'hffff_ffff);
		reg_read(8'h44, 32'h0000_0fff);
		reg_write(8'h48, 32'hffff_ffff);
		reg_read(8'h48, {8'hff, 16'h001b, ports});
		check("all set outputs", 32'h0000_0fff, {20'h0, no_overcurrent_guard, overcurrent_report_mode,
			ports_always_on, switching_mode, power_good_delay});
		reg_write(8'h48, 32'h5a00_0000);
		check("cleared outputs", 32'h0000_005a, {20'h0, no_overcurrent_guard, overcurrent_report_mode,
			ports_always_on, switching_mode, power_good_delay});
		reg_read(8'h48, {8'h5a, 16'h0000, ports});
		reg_read(8'h40, 32'h0000_0000);
		$display("test register access done");
		write_read(8'h44, 32'h0000_0100, 32'h0000_0100);
		gate(1'b1, 14'h0100, 1'b1);
		gate(1'b1, 14'h00ff, 1'b0);
		gate(1'b0, 14'h3fff, 1'b0);
		gate(1'b1, 14'h3fff, 1'b1);
		reg_read(8'h44, 32'h0000_0100);
		$display("test low-speed gate done");
		print_verdict();
	end
endmodule : tb
